// file: link_timing_pkg.sv
// Constants, register map and field layout of the link timing and coexistence block.
// Assumes a 25 MHz block clock and a plain strobe-based register port.
`default_nettype none

package link_timing_pkg;

  // Bus widths
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] TIMGEN_OFS = 32'h400000F0;
  localparam logic [ADDR_W-1:0] COARSE_OFS = 32'h400000F4;
  localparam logic [ADDR_W-1:0] FINE_OFS = 32'h400000F8;
  localparam logic [ADDR_W-1:0] SNAP_TRIG_OFS = 32'h400000FC;
  localparam logic [ADDR_W-1:0] COEX0_OFS = 32'h40000100;
  localparam logic [ADDR_W-1:0] COEX1_OFS = 32'h40000104;
  localparam logic [ADDR_W-1:0] SNAP_COUNT_OFS = 32'h40000120;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 32'h40000124;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 32'h40000128;

  // Timing generator control fields
  localparam int unsigned EARLY_ABORT_BIT = 31;
  localparam int unsigned FORCED_ABORT_LSB = 16;
  localparam int unsigned FORCED_ABORT_W = 10;
  localparam int unsigned TABLE_FETCH_LSB = 0;
  localparam int unsigned TABLE_FETCH_W = 9;
  localparam logic EARLY_ABORT_RST = 1'h1;
  localparam logic [FORCED_ABORT_W-1:0] FORCED_ABORT_RST = 10'h1FE;
  localparam logic [TABLE_FETCH_W-1:0] TABLE_FETCH_RST = 9'h096;

  // Base time and targets
  localparam int unsigned BASE_W = 27;
  localparam int unsigned COARSE_W = 23;
  localparam int unsigned COARSE_SHIFT = 4;
  localparam int unsigned SNAP_BIT = 0;

  // Coexistence control fields
  localparam int unsigned RX_MODE_LSB = 20;
  localparam int unsigned TX_MODE_LSB = 16;
  localparam int unsigned WTX_EFF_LSB = 6;
  localparam int unsigned WRX_EFF_LSB = 4;
  localparam int unsigned SYNC_EN_BIT = 1;
  localparam int unsigned COEXIST_IF_ENABLE_BIT = 0;
  localparam logic [1:0] WTX_EFF_RST = 2'h0;
  localparam logic [1:0] WRX_EFF_RST = 2'h1;
  localparam int unsigned TX_THR_LSB = 16;
  localparam int unsigned RX_THR_LSB = 24;
  localparam int unsigned THR_W = 5;
  localparam int unsigned HOLD_LSB = 8;
  localparam int unsigned HOLD_W = 7;
  localparam int unsigned PTI_W = 4;

  // Interrupt status bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_COARSE = 0;
  localparam int unsigned IRQ_FINE = 1;
  localparam int unsigned IRQ_SNAP = 2;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned SLOT_US = 625;
  localparam int unsigned US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOT_CYCLES = SLOT_US * US_NS / CLK_PERIOD_NS;

  // Coexistence indication modes, in field encoding order
  typedef enum logic [1:0] {
    MODE_NO_PWRUP,
    MODE_WITH_PWRUP,
    MODE_HIGH_PRIO,
    MODE_UNUSED
  } coex_mode_t;

endpackage

`default_nettype wire

// file: link_timing_coex_ctrl.sv
// Link timing and coexistence control: timing registers, base time slot counter,
// coarse and fine target interrupts, time snapshot and the WLAN/MWS coexistence port.
// Assumes radio status inputs are on ref_clk; wlan_tx and wlan_rx are asynchronous pins.
//
// Summary of operation
// - Early abort enable bit, 1 enables, comes out of reset enabled.
// - Ten-bit forced abort instant in microseconds, bits 25:16, resets to 0x1FE.
// - Nine-bit table fetch instant in microseconds, bits 8:0, resets to 0x96.
// - Coarse event when target equals count bits 26:4 and bits 3:0 are zero.
// - Coarse comparison resolves to 10 ms boundaries of the base time.
// - Fine event when the 27-bit fine target equals the whole base count.
// - Writing 1 to snapshot bit copies the count; the bit clears itself after.
// - RX mode picks correlator indication, powered indication or high priority output.
// - TX mode picks indication without power-up, with power-up, or high priority.
// - WLAN transmit effect field chooses whether it stops radio TX, RX, both.
// - WLAN receive effect field does the same, reset default stops TX only.
// - Sync enable bit lets the sync pulse reach the coexistence port.
// - Coexistence enable bit gates the whole coexistence port, reset disabled.
// - High priority TX is flagged when priority exceeds the TX threshold.
// - High priority RX is flagged when priority exceeds the RX threshold.
// - Priority held for programmed microseconds; zero holds until enable drops.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module link_timing_coex_ctrl #(
  parameter int unsigned SLOT_CYCLES = link_timing_pkg::SLOT_CYCLES
) (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Register port
  input wire logic [link_timing_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [link_timing_pkg::DATA_W-1:0] reg_wr_data,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  output logic [link_timing_pkg::DATA_W-1:0] reg_rd_data,
  // Interrupt
  output logic irq,
  // Exchange table engine settings and time base
  output logic early_abort_enable,
  output logic [link_timing_pkg::FORCED_ABORT_W-1:0] forced_abort_instant_us,
  output logic [link_timing_pkg::TABLE_FETCH_W-1:0] table_fetch_instant_us,
  output logic [link_timing_pkg::BASE_W-1:0] base_time_count,
  // Radio status
  input wire logic radio_tx_en,
  input wire logic radio_tx_pwrup,
  input wire logic radio_rx_en,
  input wire logic radio_rx_corr_en,
  input wire logic [link_timing_pkg::PTI_W-1:0] radio_pti,
  // Coexistence port
  input wire logic wlan_tx,
  input wire logic wlan_rx,
  output logic coex_tx,
  output logic coex_rx,
  output logic coex_sync,
  output logic radio_tx_stop,
  output logic radio_rx_stop
);
  import link_timing_pkg::*;

  localparam int unsigned SLOT_W = $clog2(SLOT_CYCLES + 1);
  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_CYCLES - 1);
  localparam int unsigned US_W = $clog2(US_CYCLES + 1);
  localparam logic [US_W-1:0] US_LAST = US_W'(US_CYCLES - 1);

  logic rst_n, early_abort_ff, sync_en_ff, coexist_if_enable_ff, slot_end, us_tick;
  logic coarse_match, fine_match, coarse_prev_ff, fine_prev_ff, coarse_evt, fine_evt;
  logic snap_pend_ff, irq_ff, sync_ff;
  logic wr_timgen, wr_coarse, wr_fine, wr_trig, wr_coex0, wr_coex1, wr_stat, wr_mask;
  logic [1:0] rst_sync_ff, rx_mode_ff, tx_mode_ff, wtx_eff_ff, wrx_eff_ff;
  logic [1:0] wlan_in, wlan_s_ff, chan_en, prio_hi_ff, ind_ff, stop_ff;
  logic [FORCED_ABORT_W-1:0] forced_abort_ff;
  logic [TABLE_FETCH_W-1:0] table_fetch_ff;
  logic [COARSE_W-1:0] coarse_tgt_ff;
  logic [BASE_W-1:0] fine_tgt_ff, base_ff, snap_count_ff;
  logic [THR_W-1:0] tx_thr_ff, rx_thr_ff;
  logic [HOLD_W-1:0] hold_time_ff;
  logic [SLOT_W-1:0] slot_cnt_ff;
  logic [US_W-1:0] us_cnt_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff, irq_evt;
  logic [DATA_W-1:0] rd_data_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_timgen = clk_en & reg_wr_stb & (reg_addr == TIMGEN_OFS);
  assign wr_coarse = clk_en & reg_wr_stb & (reg_addr == COARSE_OFS);
  assign wr_fine = clk_en & reg_wr_stb & (reg_addr == FINE_OFS);
  assign wr_trig = clk_en & reg_wr_stb & (reg_addr == SNAP_TRIG_OFS);
  assign wr_coex0 = clk_en & reg_wr_stb & (reg_addr == COEX0_OFS);
  assign wr_coex1 = clk_en & reg_wr_stb & (reg_addr == COEX1_OFS);
  assign wr_stat = clk_en & reg_wr_stb & (reg_addr == IRQ_STAT_OFS);
  assign wr_mask = clk_en & reg_wr_stb & (reg_addr == IRQ_MASK_OFS);
  // Timing generator control and targets
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      early_abort_ff <= EARLY_ABORT_RST;
      forced_abort_ff <= FORCED_ABORT_RST;
      table_fetch_ff <= TABLE_FETCH_RST;
      coarse_tgt_ff <= '0;
      fine_tgt_ff <= '0;
    end else begin
      if (wr_timgen) begin
        early_abort_ff <= reg_wr_data[EARLY_ABORT_BIT];
        forced_abort_ff <= reg_wr_data[FORCED_ABORT_LSB +: FORCED_ABORT_W];
        table_fetch_ff <= reg_wr_data[TABLE_FETCH_LSB +: TABLE_FETCH_W];
      end
      if (wr_coarse) begin
        coarse_tgt_ff <= reg_wr_data[COARSE_W-1:0];
      end
      if (wr_fine) begin
        fine_tgt_ff <= reg_wr_data[BASE_W-1:0];
      end
    end
  end
  // Coexistence control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_mode_ff <= 2'h0;
      tx_mode_ff <= 2'h0;
      wtx_eff_ff <= WTX_EFF_RST;
      wrx_eff_ff <= WRX_EFF_RST;
      sync_en_ff <= 1'h0;
      coexist_if_enable_ff <= 1'h0;
      tx_thr_ff <= '0;
      rx_thr_ff <= '0;
      hold_time_ff <= '0;
    end else begin
      if (wr_coex0) begin
        rx_mode_ff <= reg_wr_data[RX_MODE_LSB +: 2];
        tx_mode_ff <= reg_wr_data[TX_MODE_LSB +: 2];
        wtx_eff_ff <= reg_wr_data[WTX_EFF_LSB +: 2];
        wrx_eff_ff <= reg_wr_data[WRX_EFF_LSB +: 2];
        sync_en_ff <= reg_wr_data[SYNC_EN_BIT];
        coexist_if_enable_ff <= reg_wr_data[COEXIST_IF_ENABLE_BIT];
      end
      if (wr_coex1) begin
        tx_thr_ff <= reg_wr_data[TX_THR_LSB +: THR_W];
        rx_thr_ff <= reg_wr_data[RX_THR_LSB +: THR_W];
        hold_time_ff <= reg_wr_data[HOLD_LSB +: HOLD_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slot and microsecond prescalers
  assign slot_end = clk_en & (slot_cnt_ff == SLOT_LAST);
  assign us_tick = clk_en & (us_cnt_ff == US_LAST);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt_ff <= '0;
      us_cnt_ff <= '0;
    end else if (clk_en) begin
      slot_cnt_ff <= (slot_cnt_ff == SLOT_LAST) ? '0 : slot_cnt_ff + 1'h1;
      us_cnt_ff <= (us_cnt_ff == US_LAST) ? '0 : us_cnt_ff + 1'h1;
    end
  end
  // Base time advances one step per slot
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_ff <= '0;
    end else if (slot_end) begin
      base_ff <= base_ff + 1'h1;
    end
  end
  // Target comparisons; an event only on the rising edge of a match
  assign coarse_match = (coarse_tgt_ff == base_ff[BASE_W-1:COARSE_SHIFT]) &&
                        (base_ff[COARSE_SHIFT-1:0] == '0);
  assign fine_match = (fine_tgt_ff == base_ff);
  assign coarse_evt = clk_en & coarse_match & ~coarse_prev_ff;
  assign fine_evt = clk_en & fine_match & ~fine_prev_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      coarse_prev_ff <= 1'h0;
      fine_prev_ff <= 1'h0;
    end else if (clk_en) begin
      coarse_prev_ff <= coarse_match;
      fine_prev_ff <= fine_match;
    end
  end
  // Snapshot request and copy of the base count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_pend_ff <= 1'h0;
      snap_count_ff <= '0;
    end else if (clk_en) begin
      if (snap_pend_ff) begin
        snap_count_ff <= base_ff;
        snap_pend_ff <= 1'h0;
      end else if (wr_trig && reg_wr_data[SNAP_BIT]) begin
        snap_pend_ff <= 1'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status, write one to clear, a new event wins over the clear
  assign irq_evt = {clk_en & snap_pend_ff, fine_evt, coarse_evt};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff <= 1'h0;
    end else if (clk_en) begin
      irq_stat_ff <= (irq_stat_ff & ~(wr_stat ? reg_wr_data[IRQ_W-1:0] : '0)) | irq_evt;
      if (wr_mask) begin
        irq_mask_ff <= reg_wr_data[IRQ_W-1:0];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Coexistence channels: index 0 is TX, index 1 is RX
  assign wlan_in = {wlan_rx, wlan_tx};
  assign chan_en = {radio_rx_en, radio_tx_en};
  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic [2:0] pin_sync_ff;
    logic en_prev_ff, raw_ind;
    logic [HOLD_W-1:0] hold_cnt_ff;
    logic [THR_W-1:0] thr;
    coex_mode_t mode;
    logic [1:0] own_eff;
    // Three-stage pin capture; a change counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_sync_ff <= 3'h0;
        wlan_s_ff[i] <= 1'h0;
      end else if (clk_en) begin
        pin_sync_ff <= {pin_sync_ff[1:0], wlan_in[i]};
        if (pin_sync_ff[1] == pin_sync_ff[2]) begin
          wlan_s_ff[i] <= pin_sync_ff[2];
        end
      end
    end
    // Priority latched at enable rise and held for the programmed time
    assign thr = (i == 0) ? tx_thr_ff : rx_thr_ff;
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        en_prev_ff <= 1'h0;
        prio_hi_ff[i] <= 1'h0;
        hold_cnt_ff <= '0;
      end else if (clk_en) begin
        en_prev_ff <= chan_en[i];
        if (!chan_en[i]) begin
          prio_hi_ff[i] <= 1'h0;
          hold_cnt_ff <= '0;
        end else if (!en_prev_ff) begin
          prio_hi_ff[i] <= ({1'h0, radio_pti} > thr);
          hold_cnt_ff <= hold_time_ff;
        end else if (us_tick && hold_cnt_ff != '0) begin
          hold_cnt_ff <= hold_cnt_ff - 1'h1;
          if (hold_cnt_ff == HOLD_W'(1)) begin
            prio_hi_ff[i] <= 1'h0;
          end
        end
      end
    end
    // Indication selected by the channel mode
    assign mode = coex_mode_t'((i == 0) ? tx_mode_ff : rx_mode_ff);
    always_comb begin
      raw_ind = 1'h0;
      unique case (mode)
        MODE_NO_PWRUP: raw_ind = (i == 0) ? (radio_tx_en & ~radio_tx_pwrup)
                                          : radio_rx_corr_en;
        MODE_WITH_PWRUP: raw_ind = chan_en[i];
        MODE_HIGH_PRIO: raw_ind = chan_en[i] & prio_hi_ff[i];
        MODE_UNUSED: raw_ind = 1'h0;
      endcase
    end
    // Indication and stop outputs, all gated by the interface enable
    assign own_eff = {wrx_eff_ff[i], wtx_eff_ff[i]};
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ind_ff[i] <= 1'h0;
        stop_ff[i] <= 1'h0;
      end else if (clk_en) begin
        ind_ff[i] <= coexist_if_enable_ff & raw_ind;
        stop_ff[i] <= coexist_if_enable_ff & |(own_eff & wlan_s_ff);
      end
    end
  end
  // Sync pulse on every slot boundary when allowed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_ff <= 1'h0;
    end else if (clk_en) begin
      sync_ff <= slot_end & coexist_if_enable_ff & sync_en_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= '0;
    end else if (clk_en) begin
      rd_data_ff <= '0;
      if (reg_rd_stb) begin
        unique case (reg_addr)
          TIMGEN_OFS: begin
            rd_data_ff[EARLY_ABORT_BIT] <= early_abort_ff;
            rd_data_ff[FORCED_ABORT_LSB +: FORCED_ABORT_W] <= forced_abort_ff;
            rd_data_ff[TABLE_FETCH_LSB +: TABLE_FETCH_W] <= table_fetch_ff;
          end
          COARSE_OFS: rd_data_ff[COARSE_W-1:0] <= coarse_tgt_ff;
          FINE_OFS: rd_data_ff[BASE_W-1:0] <= fine_tgt_ff;
          SNAP_TRIG_OFS: rd_data_ff[SNAP_BIT] <= snap_pend_ff;
          COEX0_OFS: begin
            rd_data_ff[RX_MODE_LSB +: 2] <= rx_mode_ff;
            rd_data_ff[TX_MODE_LSB +: 2] <= tx_mode_ff;
            rd_data_ff[WTX_EFF_LSB +: 2] <= wtx_eff_ff;
            rd_data_ff[WRX_EFF_LSB +: 2] <= wrx_eff_ff;
            rd_data_ff[SYNC_EN_BIT] <= sync_en_ff;
            rd_data_ff[COEXIST_IF_ENABLE_BIT] <= coexist_if_enable_ff;
          end
          COEX1_OFS: begin
            rd_data_ff[TX_THR_LSB +: THR_W] <= tx_thr_ff;
            rd_data_ff[RX_THR_LSB +: THR_W] <= rx_thr_ff;
            rd_data_ff[HOLD_LSB +: HOLD_W] <= hold_time_ff;
          end
          SNAP_COUNT_OFS: rd_data_ff[BASE_W-1:0] <= snap_count_ff;
          IRQ_STAT_OFS: rd_data_ff[IRQ_W-1:0] <= irq_stat_ff;
          IRQ_MASK_OFS: rd_data_ff[IRQ_W-1:0] <= irq_mask_ff;
          default: rd_data_ff <= '0;
        endcase
      end
    end
  end
  // Outputs straight from flops
  assign reg_rd_data = rd_data_ff;
  assign irq = irq_ff;
  assign early_abort_enable = early_abort_ff;
  assign forced_abort_instant_us = forced_abort_ff;
  assign table_fetch_instant_us = table_fetch_ff;
  assign base_time_count = base_ff;
  assign coex_tx = ind_ff[0];
  assign coex_rx = ind_ff[1];
  assign radio_tx_stop = stop_ff[0];
  assign radio_rx_stop = stop_ff[1];
  assign coex_sync = sync_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_early_abort_wr: assert property (wr_timgen |=>
    early_abort_ff == $past(reg_wr_data[EARLY_ABORT_BIT])) else $error("early abort bit lost");
  a_forced_abort_wr: assert property (wr_timgen |=>
    forced_abort_ff == $past(reg_wr_data[FORCED_ABORT_LSB +: FORCED_ABORT_W]))
    else $error("forced abort field lost");
  a_table_fetch_wr: assert property (wr_timgen |=>
    table_fetch_ff == $past(reg_wr_data[TABLE_FETCH_LSB +: TABLE_FETCH_W]))
    else $error("table fetch field lost");
  a_coarse_match: assert property ($rose(irq_stat_ff[IRQ_COARSE]) |->
    $past(base_ff[COARSE_SHIFT-1:0]) == '0 &&
    $past(coarse_tgt_ff) == $past(base_ff[BASE_W-1:COARSE_SHIFT]))
    else $error("coarse event off boundary");
  a_fine_match: assert property ($rose(irq_stat_ff[IRQ_FINE]) |->
    $past(fine_tgt_ff) == $past(base_ff)) else $error("fine event without match");
  a_fine_once: assert property (fine_evt |=> !fine_evt)
    else $error("fine event repeated");
  a_slot_step: assert property ($changed(base_ff) |-> $past(slot_cnt_ff) == SLOT_LAST)
    else $error("base count stepped mid slot");
  a_snapshot_copy: assert property ((wr_trig && reg_wr_data[SNAP_BIT] && !snap_pend_ff)
    ##1 clk_en |=> !snap_pend_ff && snap_count_ff == $past(base_ff))
    else $error("snapshot not copied");
  a_rx_powered_ind: assert property ((clk_en && coexist_if_enable_ff && rx_mode_ff == 2'h1)
    |=> coex_rx == $past(radio_rx_en)) else $error("rx indication wrong");
  a_coex_disabled: assert property ((clk_en && !coexist_if_enable_ff) |=>
    !coex_tx && !coex_rx && !radio_tx_stop && !radio_rx_stop)
    else $error("coexistence output while disabled");
  a_tx_prio_latch: assert property ((clk_en && radio_tx_en && !g_chan[0].en_prev_ff)
    |=> prio_hi_ff[0] == ($past(radio_pti) > $past(tx_thr_ff)))
    else $error("tx priority not latched");
  c_coarse_evt: cover property (coarse_evt && base_ff != '0);
  c_fine_evt: cover property (fine_evt && base_ff != '0);
  c_snapshot: cover property (snap_pend_ff ##1 !snap_pend_ff);
  c_tx_high: cover property (coex_tx && tx_mode_ff == 2'h2);

endmodule

`default_nettype wire

// file: coex_arbiter_model.sv
// Behavioural WLAN/MWS arbiter standing at the far side of the coexistence port.
// Assumes the bench requests WLAN activity and clears the sync counter.
`timescale 1ns/1ps
`default_nettype none

module coex_arbiter_model (
  // Clock
  input wire logic ref_clk,
  // Bench requests
  input wire logic want_tx,
  input wire logic want_rx,
  input wire logic count_clr,
  // Coexistence port
  input wire logic coex_sync,
  output logic wlan_tx = 1'b0,
  output logic wlan_rx = 1'b0,
  output logic [7:0] sync_count = 8'h00
);
  // WLAN activity pins change just after an edge, unrelated to the radio
  always @(posedge ref_clk) begin
    wlan_tx <= want_tx;
    wlan_rx <= want_rx;
  end

  // Count sync pulses offered by the radio side
  always @(posedge ref_clk) begin
    if (count_clr) begin
      sync_count <= 8'h00;
    end else if (coex_sync) begin
      sync_count <= sync_count + 8'h01;
    end
  end
endmodule

`default_nettype wire

// file: test_link_timing_coex_ctrl.sv
// Self-checking bench for the link timing and coexistence block.
// Assumes a short slot so that the base time moves quickly.
`timescale 1ns/1ps
`default_nettype none

module test_link_timing_coex_ctrl;
  import link_timing_pkg::*;
  localparam int unsigned SLOTS = 40;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 32'h0;
  logic [DATA_W-1:0] reg_wr_data = 32'h0;
  logic reg_wr_stb = 1'b0;
  logic reg_rd_stb = 1'b0;
  logic [DATA_W-1:0] reg_rd_data;
  logic irq, early_abort_enable, coex_tx, coex_rx, coex_sync, radio_tx_stop, radio_rx_stop;
  logic [FORCED_ABORT_W-1:0] forced_abort_instant_us;
  logic [TABLE_FETCH_W-1:0] table_fetch_instant_us;
  logic [BASE_W-1:0] base_time_count;
  logic radio_tx_en = 1'b0;
  logic radio_tx_pwrup = 1'b0;
  logic radio_rx_en = 1'b0;
  logic radio_rx_corr_en = 1'b0;
  logic [PTI_W-1:0] radio_pti = 4'h0;
  logic want_tx = 1'b0;
  logic want_rx = 1'b0;
  logic count_clr = 1'b0;
  logic clk_en = 1'b1;
  logic wlan_tx, wlan_rx;
  logic [7:0] sync_count;
  logic [31:0] d;
  int failures = 0;
  int checks_done = 0;

  link_timing_coex_ctrl #(.SLOT_CYCLES(SLOTS)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb),
    .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data), .irq(irq),
    .early_abort_enable(early_abort_enable), .forced_abort_instant_us(forced_abort_instant_us),
    .table_fetch_instant_us(table_fetch_instant_us), .base_time_count(base_time_count),
    .radio_tx_en(radio_tx_en), .radio_tx_pwrup(radio_tx_pwrup), .radio_rx_en(radio_rx_en),
    .radio_rx_corr_en(radio_rx_corr_en), .radio_pti(radio_pti), .wlan_tx(wlan_tx),
    .wlan_rx(wlan_rx), .coex_tx(coex_tx), .coex_rx(coex_rx), .coex_sync(coex_sync),
    .radio_tx_stop(radio_tx_stop), .radio_rx_stop(radio_rx_stop));

  coex_arbiter_model far_end (.ref_clk(ref_clk), .want_tx(want_tx), .want_rx(want_rx),
    .count_clr(count_clr), .coex_sync(coex_sync), .wlan_tx(wlan_tx), .wlan_rx(wlan_rx),
    .sync_count(sync_count));

  // Block clock, 40 ns period
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wr_data <= v;
    reg_wr_stb <= 1'b1;
    @(posedge ref_clk);
    reg_wr_stb <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd_stb <= 1'b1;
    @(posedge ref_clk);
    reg_rd_stb <= 1'b0;
    #1;
    v = reg_rd_data;
  endtask

  // Compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Bounded wait for the interrupt line
  task automatic wait_irq(input int bound);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < bound) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (irq !== 1'b1) begin
      chk("irq", 32'h1, {31'h0, irq});
      test_done();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(TIMGEN_OFS, d);
    chk("timing_gen_control", 32'h81FE0096, d);
    rd(COEX0_OFS, d);
    chk("coexistence_control", 32'h00000010, d);
    rd(32'h400000EC, d);
    chk("unmapped", 32'h0, d);
    wr(TIMGEN_OFS, 32'h01550123);
    rd(TIMGEN_OFS, d);
    chk("timing_gen_control", 32'h01550123, d);
    chk("timing_outputs", 32'h01550123, {early_abort_enable, 5'h0, forced_abort_instant_us,
      7'h0, table_fetch_instant_us});
    // Fine target, then snapshot at the same base value
    wr(IRQ_STAT_OFS, 32'h7);
    wr(IRQ_MASK_OFS, 32'h3);
    wr(FINE_OFS, 32'h8);
    wait_irq(600);
    chk("base_at_fine", 32'h8, 32'(base_time_count));
    wr(SNAP_TRIG_OFS, 32'h1);
    rd(SNAP_TRIG_OFS, d);
    chk("time_snapshot_trigger", 32'h0, d);
    rd(SNAP_COUNT_OFS, d);
    chk("snapshot_count", 32'h8, d);
    rd(IRQ_STAT_OFS, d);
    chk("irq_status", 32'h6, d);
    wr(IRQ_STAT_OFS, 32'h6);
    rd(IRQ_STAT_OFS, d);
    chk("irq_status_cleared", 32'h0, d);
    chk("irq_low", 32'h0, {31'h0, irq});
    // Coarse target on a 16-slot boundary
    wr(IRQ_MASK_OFS, 32'h1);
    wr(COARSE_OFS, 32'h1);
    wait_irq(900);
    chk("base_at_coarse", 32'h10, 32'(base_time_count));
    // Target rewritten inside its 16-slot step but off the boundary: no event
    repeat (SLOTS) @(posedge ref_clk);
    wr(IRQ_STAT_OFS, 32'h1);
    wr(COARSE_OFS, 32'h1);
    rd(IRQ_STAT_OFS, d);
    chk("coarse_off_boundary", 32'h0, d);
    // Clock enable low freezes the base time and drops register writes
    d = 32'(base_time_count);
    clk_en <= 1'b0;
    wr(FINE_OFS, 32'h3);
    repeat (2 * SLOTS) @(posedge ref_clk);
    #1;
    chk("base_frozen", d, 32'(base_time_count));
    clk_en <= 1'b1;
    rd(FINE_OFS, d);
    chk("fine_target_kept", 32'h8, d);
    // Indication modes with priority thresholds
    wr(COEX1_OFS, 32'h07040000);
    radio_pti <= 4'h5;
    radio_tx_pwrup <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(COEX0_OFS, {10'h0, 2'(m), 2'h0, 2'(m), 16'h0001});
      radio_tx_en <= 1'b1;
      radio_rx_en <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("coex_tx", 32'((4'b0110 >> m) & 4'h1), {31'h0, coex_tx});
      chk("coex_rx", 32'((4'b0010 >> m) & 4'h1), {31'h0, coex_rx});
      radio_tx_en <= 1'b0;
      radio_rx_en <= 1'b0;
    end
    // Priority held two microseconds only
    wr(COEX1_OFS, 32'h07040200);
    wr(COEX0_OFS, 32'h00020001);
    radio_tx_en <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("coex_tx_held", 32'h1, {31'h0, coex_tx});
    repeat (80) @(posedge ref_clk);
    #1;
    chk("coex_tx_expired", 32'h0, {31'h0, coex_tx});
    wr(COEX0_OFS, 32'h00010000);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("coex_tx_disabled", 32'h0, {31'h0, coex_tx});
    radio_tx_en <= 1'b0;
    // WLAN activity effects on the radio
    for (int e = 0; e < 4; e++) begin
      wr(COEX0_OFS, {24'h0, 2'(e), 2'(3 - e), 4'h1});
      want_tx <= 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      chk("stop_by_wlan_tx", 32'(e), {30'h0, radio_rx_stop, radio_tx_stop});
      want_tx <= 1'b0;
      want_rx <= 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      chk("stop_by_wlan_rx", 32'(3 - e), {30'h0, radio_rx_stop, radio_tx_stop});
      want_rx <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
    // Sync pulses over two slots, with and without the enable
    for (int s = 0; s < 2; s++) begin
      wr(COEX0_OFS, 32'(1 + 2 * s));
      count_clr <= 1'b1;
      @(posedge ref_clk);
      count_clr <= 1'b0;
      repeat (2 * SLOTS) @(posedge ref_clk);
      #1;
      chk("sync_count", 32'(2 * s), 32'(sync_count));
    end
    test_done();
  end
endmodule

`default_nettype wire
